/* File: dv/balance_fault_gating_watchdog_monitor.sv */
// Port checker for the balance fault gating watchdog.
// Assumes one clock domain and the bind below.
`timescale 1ns/1ns
`default_nettype none
module balance_fault_gating_watchdog_monitor (
	input wire logic                            core_clk,
	input wire logic                            nrst,
	input wire balance_guard_pkg::cell_vec_type gate_ok_raw,
	input wire logic                            overtemp,
	input wire logic                            ontime_clamp_defeated,
	input wire balance_guard_pkg::cell_vec_type command_active,
	input wire logic                            execute_start,
	input wire logic                            watchdog_pin_in,
	input wire logic                            watchdog_pin_oe,
	input wire balance_guard_pkg::cell_vec_type balancer_enable,
	input wire logic                            watchdog_expired,
	input wire logic                            thermal_shutdown,
	input wire logic                            overvoltage_shutdown
);
	import balance_guard_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic [5:0] low_cnt;
	// Saturates so a long outage never wraps
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst) low_cnt <= 6'h00;
		else if (gate_ok_raw[0]) low_cnt <= 6'h00;
		else if (low_cnt != 6'h3f) low_cnt <= low_cnt + 6'h01;
	AST_CMD_GATE: assert property ((balancer_enable & ~$past(command_active)) == 6'h00)
		else $error("enable without command");
	AST_GATE_LOSS: assert property (low_cnt >= 6'h21 |-> !balancer_enable[0])
		else $error("enable kept after gate loss");
	AST_OV_OFF: assert property (overvoltage_shutdown |-> balancer_enable == 6'h00)
		else $error("enable during overvoltage");
	// Out of reset for a full cycle, so the registered copy has caught up
	AST_THERMAL: assert property ($past(nrst) && $past(overtemp) |-> thermal_shutdown && !(|balancer_enable))
		else $error("enable during overtemp");
	AST_WD_START: assert property (execute_start && command_active != 6'h00 && !watchdog_expired
		&& !ontime_clamp_defeated ##1 !ontime_clamp_defeated |=> watchdog_pin_oe)
		else $error("pin not pulled after execute");
	// Expired flag trails the state by one cycle, so check in the same cycle; a tied-low pin
	// switches the timeout effect off
	AST_EXPIRED: assert property (watchdog_expired && !$past(ontime_clamp_defeated)
		&& $past(watchdog_pin_in) |-> !watchdog_pin_oe && balancer_enable == 6'h00)
		else $error("timeout not applied");
	AST_CLAMP: assert property (ontime_clamp_defeated && $past(ontime_clamp_defeated)
		|-> !watchdog_pin_oe) else $error("pin pulled with clamp off");
	AST_PAUSE: assert property (watchdog_pin_oe && watchdog_pin_in && !ontime_clamp_defeated
		&& !watchdog_expired |=> balancer_enable == 6'h00) else $error("pause ignored");
	AST_POR: assert property ($rose(nrst) |-> balancer_enable == 6'h00 && !watchdog_pin_oe)
		else $error("outputs active after reset");
endmodule // balance_fault_gating_watchdog_monitor
bind balance_fault_gating_watchdog balance_fault_gating_watchdog_monitor u_mon (
	.core_clk(core_clk), .nrst(nrst), .gate_ok_raw(gate_ok_raw), .overtemp(overtemp),
	.ontime_clamp_defeated(ontime_clamp_defeated), .command_active(command_active),
	.execute_start(execute_start), .watchdog_pin_in(watchdog_pin_in),
	.watchdog_pin_oe(watchdog_pin_oe), .balancer_enable(balancer_enable),
	.watchdog_expired(watchdog_expired), .thermal_shutdown(thermal_shutdown),
	.overvoltage_shutdown(overvoltage_shutdown));
`default_nettype wire

/* File: dv/balance_fault_gating_watchdog_test.sv */
// Self-checking bench for the balance fault gating watchdog.
// Assumes the host model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module balance_fault_gating_watchdog_test;
	import balance_guard_pkg::*;
	localparam int WD = 400;
	logic         core_clk, nrst, next_ok, boost, otemp, clamp, exec_start, req, pause;
	logic         cs_n, strobe, bval, busy, pin_in, pin_out, pin_oe, balancing, expired;
	logic         tshut, ovshut;
	cell_vec_type gate, ov, cmd, en;
	logic [7:0]   tx;
	logic [7:0]   cmds [4] = '{8'ha9, 8'haa, 8'hac, 8'haf};
	int           n_mismatch, total_checks;
	balance_fault_gating_watchdog #(.WDOG_TIMEOUT_CYCLES(WD)) u_dut (.core_clk(core_clk),
		.nrst(nrst), .gate_ok_raw(gate), .next_device_gate_ok_raw(next_ok),
		.overvoltage_raw(ov), .boost_enable(boost), .overtemp(otemp),
		.ontime_clamp_defeated(clamp), .cs_n(cs_n), .bit_strobe(strobe), .bit_value(bval),
		.command_active(cmd), .execute_start(exec_start), .watchdog_pin_in(pin_in),
		.watchdog_pin_out(pin_out), .watchdog_pin_oe(pin_oe), .balancer_enable(en),
		.balancing(balancing), .watchdog_expired(expired), .thermal_shutdown(tshut),
		.overvoltage_shutdown(ovshut));
	host_pin_model u_host (.core_clk(core_clk), .req(req), .tx_byte(tx), .pin_oe(pin_oe),
		.pause_drive(pause), .cs_n(cs_n), .bit_strobe(strobe), .bit_value(bval),
		.busy(busy), .pin_in(pin_in));
	function automatic cell_vec_type exp_en(cell_vec_type g, logic nx, logic bst);
		exp_en = {g[5] & (bst | nx), g[4:0] & g[5:1]};
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic send(input logic [7:0] b);
		tx = b;
		req = 1'b1;
		step(1);
		req = 1'b0;
		@(posedge core_clk);
		while (busy) @(posedge core_clk);
		#1;
	endtask
	// One framed byte outlasts the filter and enable latency
	task automatic settle();
		send(cmds[$urandom_range(0, 3)]);
	endtask
	task automatic send_bad(input int n);
		logic [7:0] b;
		repeat (n) begin
			b = 8'($urandom);
			if (b[7:3] == 5'h15) b[7] = 1'b0;
			send(b);
		end
	endtask
	task automatic finish_test();
		if (n_mismatch == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		#(20000 * 100);
		n_mismatch++;
		finish_test();
	end
	initial begin
		{nrst, next_ok, boost, otemp, clamp, exec_start, req, pause} = 8'h00;
		{gate, ov, cmd, tx} = 26'h0;
		void'($urandom(32'h41b7));
		step(20);
		nrst = 1'b1;
		`CHECK(pin_oe, 1'b0)
		{gate, next_ok, cmd, exec_start} = {6'h3f, 1'b1, 6'h3f, 1'b1};
		step(1);
		exec_start = 1'b0;
		step(20);
		`CHECK(en, 6'h00)
		settle();
		`CHECK({pin_out, pin_oe}, 2'h1)
		for (int k = 0; k < 8; k++) begin
			{gate, next_ok, boost} = 8'($urandom);
			cmd = 6'($urandom) | 6'h01;
			settle();
			`CHECK(en, exp_en(gate, next_ok, boost) & cmd)
		end
		{gate, cmd, next_ok} = {12'hfff, 1'b0};
		for (int k = 0; k < 2; k++) begin
			boost = k[0];
			settle();
			`CHECK(en[5], boost)
		end
		gate = 6'h00;
		step($urandom_range(2, 25));
		gate = 6'h3f;
		step(3);
		`CHECK(en, 6'h3f)
		ov = 6'h01 << $urandom_range(0, 5);
		settle();
		`CHECK({ovshut, en}, 7'h40)
		ov = 6'h00;
		settle();
		`CHECK({balancing, en}, 7'h7f)
		otemp = 1'b1;
		settle();
		`CHECK({tshut, expired, en}, 8'h80)
		otemp = 1'b0;
		step(2);
		`CHECK(en, 6'h3f)
		pause = 1'b1;
		step(2);
		`CHECK(en, 6'h00)
		pause = 1'b0;
		step(2);
		`CHECK({expired, en}, 7'h3f)
		send_bad(WD / 30);
		`CHECK({expired, pin_oe, en}, 8'h80)
		send(8'ha9);
		`CHECK({expired, en}, 7'h40)
		send(8'haf);
		`CHECK({expired, en}, 7'h3f)
		clamp = 1'b1;
		send_bad(WD / 30);
		`CHECK({pin_oe, en}, 7'h3f)
		nrst = 1'b0;
		step(2);
		`CHECK({balancing, pin_oe, en}, 8'h00)
		nrst = 1'b1;
		step(2);
		finish_test();
	end
endmodule // balance_fault_gating_watchdog_test
`default_nettype wire

/* File: dv/host_pin_model.sv */
// Host side: frames one command byte MSB first, resolves the watchdog pin.
// Assumes req is high for one clock edge and low again by the first edge after busy falls.
`timescale 1ns/1ns
`default_nettype none
module host_pin_model (
	input  wire logic       core_clk,
	input  wire logic       req,
	input  wire logic [7:0] tx_byte,
	input  wire logic       pin_oe,
	input  wire logic       pause_drive,
	output var  logic       cs_n,
	output var  logic       bit_strobe,
	output var  logic       bit_value,
	output var  logic       busy,
	output var  logic       pin_in
);
	// Pull-up when released; external high beats our sink
	assign pin_in = pause_drive | ~pin_oe;
	initial begin
		cs_n = 1'b1;
		bit_strobe = 1'b0;
		bit_value = 1'b0;
		busy = 1'b0;
	end
	always begin
		@(posedge core_clk iff req);
		#1 busy = 1'b1;
		cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			repeat (3) @(posedge core_clk);
			#1 bit_value = tx_byte[i];
			bit_strobe = 1'b1;
			@(posedge core_clk);
			#1 bit_strobe = 1'b0;
			// Stale data must not look held
			bit_value = ~bit_value;
		end
		repeat (2) @(posedge core_clk);
		#1 cs_n = 1'b1;
		busy = 1'b0;
	end
endmodule // host_pin_model
`default_nettype wire

/* File: rtl/balance_fault_gating_watchdog.sv */
// Top of the balancer supervisory logic: fault gating and watchdog.
// Assumes all inputs synchronous to core_clk; nrst is the supply monitor reset.
`timescale 1ns/1ns
`default_nettype none
`include "balance_guard_defines.svh"
// Functional notes
// - Enable a balancer only while its cell and the next cell exceed 2V.
// - Sixth balancer uses its own cell alone when boosted drive is selected.
// - Comparator results change only after raw state held 3us to 6us.
// - Gate drive loss turns off only the affected balancers.
// - Keep the command through gate drive loss and restart when restored.
// - Any filtered cell overvoltage above 5V disables every balancer.
// - Keep the command after overvoltage and resume once all clear.
// - Power-on or rail drop resets to defaults with no balancer active.
// - Overtemperature stops balancing while communication and readback stay live.
// - Keep the command in thermal shutdown and resume when it clears.
// - Watchdog starts when a command executes and clears on each valid byte.
// - Any byte with matching address counts as valid, even partial transfers; the code counts a byte only once its eighth bit arrives.
// - Watchdog pin floats when idle and is pulled low while balancing.
// - After 1.5 s without valid bytes, release the pin and stop balancers.
// - After timeout a valid byte restarts timing; only execute resumes balancing.
// - External high on the pin pauses balancing; release resumes it.
// - Watchdog disabled when the on-time clamp is defeated or the pin tied low.
// - Command byte recognised only when first five bits equal 10101.
module balance_fault_gating_watchdog #(
	parameter int unsigned WDOG_TIMEOUT_CYCLES = `WDOG_CYCLES
) (
	input  wire logic                         core_clk,
	input  wire logic                         nrst,
	input  wire balance_guard_pkg::cell_vec_type gate_ok_raw,
	input  wire logic                         next_device_gate_ok_raw,
	input  wire balance_guard_pkg::cell_vec_type overvoltage_raw,
	input  wire logic                         boost_enable,
	input  wire logic                         overtemp,
	input  wire logic                         ontime_clamp_defeated,
	input  wire logic                         cs_n,
	input  wire logic                         bit_strobe,
	input  wire logic                         bit_value,
	input  wire balance_guard_pkg::cell_vec_type command_active,
	input  wire logic                         execute_start,
	input  wire logic                         watchdog_pin_in,
	output var  logic                         watchdog_pin_out,
	output var  logic                         watchdog_pin_oe,
	output var  balance_guard_pkg::cell_vec_type balancer_enable,
	output var  logic                         balancing,
	output var  logic                         watchdog_expired,
	output var  logic                         thermal_shutdown,
	output var  logic                         overvoltage_shutdown
);
	import balance_guard_pkg::*;

	logic [`NUM_FILTERS-1:0] raw_all;
	logic [`NUM_FILTERS-1:0] filt_all;
	cell_vec_type            gate_ok;
	cell_vec_type            ov;
	logic                    next_gate_ok;
	cell_vec_type            qualified;
	cell_vec_type            next_enable;
	logic                    any_ov;
	logic                    wdog_off;
	logic                    paused;
	logic                    pin_tied_low;
	wdog_state_type          wdog_state;
	logic [`WDOG_CNT_W-1:0]  wdog_cnt;
	cmd_byte_if              cmd ();

	assign raw_all = {next_device_gate_ok_raw, overvoltage_raw, gate_ok_raw};
	assign gate_ok = filt_all[5:0];
	assign ov = filt_all[11:6];
	assign next_gate_ok = filt_all[12];

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_FILTERS; gi++) begin : g_filter
			comparator_filter u_filter (
				.core_clk (core_clk),
				.nrst     (nrst),
				.raw      (raw_all[gi]),
				.filtered (filt_all[gi])
			);
		end
	endgenerate

	cmd_byte_checker u_checker (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.cs_n       (cs_n),
		.bit_strobe (bit_strobe),
		.bit_value  (bit_value),
		.cmd        (cmd)
	);

	// Per-cell qualification from this and the next higher cell
	always_comb begin
		for (int i = 0; i < `NUM_CELLS - 1; i++) begin
			qualified[i] = gate_ok[i] && gate_ok[i+1];
		end
		qualified[5] = gate_ok[5] && (boost_enable || next_gate_ok);
	end

	assign any_ov = |ov;

	// Pin low while not driving means tied low: watchdog off
	assign pin_tied_low = !watchdog_pin_oe && !watchdog_pin_in;
	assign wdog_off = ontime_clamp_defeated || pin_tied_low;

	// External high only counts while the watchdog is running, not idle or expired
	assign paused = watchdog_pin_in && wdog_state == wdog_running;

	// Stored command is never touched by faults; only the enables drop
	always_comb begin
		next_enable = command_active & qualified;
		if (any_ov) begin
			next_enable = '0;
		end
		if (overtemp) begin
			next_enable = '0;
		end
		if (wdog_state == wdog_expired && !wdog_off) begin
			next_enable = '0;
		end
		if (paused && !wdog_off) begin
			next_enable = '0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			balancer_enable <= '0;
		end else begin
			balancer_enable <= next_enable;
		end
	end

	// Watchdog sequencing
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wdog_state <= wdog_idle;
			wdog_cnt <= '0;
		end else begin
			case (wdog_state)
				wdog_idle: begin
					wdog_cnt <= '0;
					if (execute_start && |command_active) begin
						wdog_state <= wdog_running;
					end
				end
				wdog_running: begin
					if (~|command_active) begin
						wdog_state <= wdog_idle;
						wdog_cnt <= '0;
					end else if (cmd.valid_byte) begin
						wdog_cnt <= '0;
					end else if (wdog_cnt >= `WDOG_CNT_W'(WDOG_TIMEOUT_CYCLES - 1)) begin
						wdog_state <= wdog_expired;
					end else begin
						wdog_cnt <= wdog_cnt + `WDOG_CNT_W'(1);
					end
				end
				wdog_expired: begin
					// A valid byte restarts timing, but only execute resumes
					if (cmd.valid_byte) begin
						wdog_cnt <= '0;
					end
					if (cmd.execute && |command_active) begin
						wdog_state <= wdog_running;
						wdog_cnt <= '0;
					end else if (~|command_active) begin
						wdog_state <= wdog_idle;
					end
				end
				default: begin
					wdog_state <= wdog_idle;
					wdog_cnt <= '0;
				end
			endcase
		end
	end

	// Pull low only while running; expired or idle leaves the pin floating
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			watchdog_pin_oe <= 1'b0;
		end else begin
			watchdog_pin_oe <= wdog_state == wdog_running && !ontime_clamp_defeated;
		end
	end

	assign watchdog_pin_out = 1'b0;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			balancing <= 1'b0;
			watchdog_expired <= 1'b0;
			thermal_shutdown <= 1'b0;
			overvoltage_shutdown <= 1'b0;
		end else begin
			balancing <= |next_enable;
			watchdog_expired <= wdog_state == wdog_expired;
			thermal_shutdown <= overtemp;
			overvoltage_shutdown <= any_ov;
		end
	end
endmodule // balance_fault_gating_watchdog
`default_nettype wire

/* File: rtl/balance_guard_defines.svh */
// Timing and sizing constants for the balance fault gating watchdog.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef BALANCE_GUARD_DEFINES_SVH
`define BALANCE_GUARD_DEFINES_SVH
`define CLK_PERIOD_NS 100
`define QUAL_MIN_NS 3000
`define QUAL_MAX_NS 6000
// Least qualification time, rounded up to whole cycles
`define QUAL_CYCLES ((`QUAL_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QUAL_CNT_W 6
`define WDOG_TIMEOUT_MS 1500
`define WDOG_CYCLES ((`WDOG_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define WDOG_CNT_W 24
`define NUM_CELLS 6
`define NUM_FILTERS 13
`define CMD_ADDR_PATTERN 5'h15
`define CMD_BYTE_W 8
`endif

/* File: rtl/balance_guard_pkg.sv */
// Types shared by the balance fault gating watchdog modules.
// Assumes nothing of its surroundings.
package balance_guard_pkg;
	typedef enum logic [1:0] {
		wdog_idle,
		wdog_running,
		wdog_expired
	} wdog_state_type;
	typedef logic [5:0] cell_vec_type;
endpackage

/* File: rtl/cmd_byte_checker.sv */
// Watches the first eight bits after chip select falls.
// Assumes bit strobes and chip select synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
`include "balance_guard_defines.svh"
module cmd_byte_checker (
	input  wire logic         core_clk,
	input  wire logic         nrst,
	input  wire logic         cs_n,
	input  wire logic         bit_strobe,
	input  wire logic         bit_value,
	cmd_byte_if.checker_side  cmd
);
	logic [`CMD_BYTE_W-1:0] shift;
	logic [3:0]             bit_cnt;
	logic [`CMD_BYTE_W-1:0] next_byte;

	assign next_byte = {shift[`CMD_BYTE_W-2:0], bit_value};

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			shift <= '0;
			bit_cnt <= '0;
		end else if (cs_n) begin
			bit_cnt <= '0;
		end else if (bit_strobe && bit_cnt != 4'h8) begin
			shift <= next_byte;
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// Later data is ignored until chip select cycles, so one check per frame
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cmd.valid_byte <= 1'b0;
			cmd.execute <= 1'b0;
		end else begin
			cmd.valid_byte <= !cs_n && bit_strobe && bit_cnt == 4'h7
				&& next_byte[7:3] == `CMD_ADDR_PATTERN;
			cmd.execute <= !cs_n && bit_strobe && bit_cnt == 4'h7
				&& next_byte[7:3] == `CMD_ADDR_PATTERN && next_byte[2:1] == 2'h3;
		end
	end
endmodule // cmd_byte_checker
`default_nettype wire

/* File: rtl/cmd_byte_if.sv */
// Carries a received command byte from the byte checker to the watchdog.
// Assumes one clock domain with the top module.
`timescale 1ns/1ns
`default_nettype none
interface cmd_byte_if;
	logic valid_byte;
	logic execute;
	modport checker_side (output valid_byte, output execute);
	modport watchdog_side (input valid_byte, input execute);
endinterface
`default_nettype wire

/* File: rtl/comparator_filter.sv */
// Qualification filter for one raw comparator result.
// Assumes the raw input is synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
`include "balance_guard_defines.svh"
module comparator_filter (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic raw,
	output var  logic filtered
);
	logic                     last_raw;
	logic [`QUAL_CNT_W-1:0]   stable_cnt;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			last_raw <= 1'b0;
			stable_cnt <= '0;
		end else if (raw != last_raw) begin
			last_raw <= raw;
			stable_cnt <= '0;
		end else if (stable_cnt != `QUAL_CNT_W'(`QUAL_CYCLES)) begin
			stable_cnt <= stable_cnt + `QUAL_CNT_W'(1);
		end
	end

	// Output moves only after the raw state held for the full interval
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			filtered <= 1'b0;
		end else if (raw == last_raw && stable_cnt == `QUAL_CNT_W'(`QUAL_CYCLES) - `QUAL_CNT_W'(1)) begin
			filtered <= last_raw;
		end
	end
endmodule // comparator_filter
`default_nettype wire
